//--- src/asz_consts.svh
// Offsets, field positions, reset values and timing counts of the sensor.
`ifndef ASZ_CONSTS_SVH
`define ASZ_CONSTS_SVH

// Register byte offsets on the Avalon-MM slave
`define ASZ_OFF_STATUS   5'h00
`define ASZ_OFF_ZERO     5'h04
`define ASZ_OFF_IRQ_ST   5'h08
`define ASZ_OFF_IRQ_MASK 5'h0c
`define ASZ_OFF_CTRL     5'h10

// Interrupt status and mask bit positions
`define ASZ_IRQ_LOAD 0
`define ASZ_IRQ_PROG 1
`define ASZ_IRQ_ZERO 2
`define ASZ_IRQ_CONT 3
`define ASZ_IRQ_W    4

// Control register: bit 0 allows one-time programming
`define ASZ_CTRL_PROG_EN 0

// Reset values
`define ASZ_MASK_RST 4'h0
`define ASZ_CTRL_RST 1'h1

// Serial word length and frame counting
`define ASZ_WORD_BITS 8
`define ASZ_FCNT_MAX  4'h9
`define ASZ_FCNT_LAST 4'h8

// Pulse counts inside programming mode (first pulse excluded)
`define ASZ_ZERO_PULSES 4'h6
`define ASZ_CONT_PULSES 4'h7

// Timing: figures as printed, cycle counts derived from the clock
`define ASZ_CLK_MHZ      50
`define ASZ_T_WAIT_NS    500
`define ASZ_MODE_ENTRY_PULSE_TIME_US  200
`define ASZ_T_ACK_US     5
`define ASZ_WAIT_CYC   ((`ASZ_T_WAIT_NS * `ASZ_CLK_MHZ + 999) / 1000)
`define ASZ_PROGEN_CYC (`ASZ_MODE_ENTRY_PULSE_TIME_US * `ASZ_CLK_MHZ)
`define ASZ_ACK_CYC    (`ASZ_T_ACK_US * `ASZ_CLK_MHZ)

`endif

//--- src/asz_pkg.sv
// Types shared by the angle sensor readout and programming logic.
package asz_pkg;

  // One completed measurement from the front end
  typedef struct packed {
    logic [5:0] angle;
    logic       invalid;
  } asz_meas_t;

  // Serial word as it leaves the shift register, MSB first
  typedef struct packed {
    logic [5:0] angle;
    logic       invalid;
    logic       parity;
  } asz_word_t;

  // Pins that come from the host, in synchroniser bit order
  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic prog_data;
    logic prog_hv;
  } asz_pins_t;

  // Programming sequence states
  typedef enum logic [2:0] {
    ASZ_PG_IDLE   = 3'b000,
    ASZ_PG_ENTRY  = 3'b001,
    ASZ_PG_ACK    = 3'b010,
    ASZ_PG_PULSES = 3'b011,
    ASZ_PG_FAIL   = 3'b100
  } asz_pg_t;

endpackage : asz_pkg

//--- src/asz_pin_sync.sv
// Two-flop synchroniser with edge detection for the host pins.
`timescale 1ns/1ps
`default_nettype none

module asz_pin_sync #(
  parameter int         W       = 4,
  parameter logic [3:0] RST_VAL = 4'h8
) (
  input  wire logic         ref_clk_i,
  input  wire logic         sys_rst_i,
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] level_o,
  output logic      [W-1:0] rise_o,
  output logic      [W-1:0] fall_o
);

  generate
    if (W < 1 || W > 4)
    begin : g_chk
      $error("asz_pin_sync: W must be 1 to 4");
    end
  endgenerate

  genvar b;
  generate
    for (b = 0; b < W; b++)
    begin : g_bit
      logic meta;
      logic stab;
      logic prev;
      // First flop feeds only the second; edges come from later stages
      always_ff @(posedge ref_clk_i or posedge sys_rst_i)
      begin
        if (sys_rst_i)
        begin
          meta <= RST_VAL[b];
          stab <= RST_VAL[b];
          prev <= RST_VAL[b];
        end
        else
        begin
          meta <= pin_i[b];
          stab <= meta;
          prev <= stab;
        end
      end
      assign level_o[b] = stab;
      assign rise_o[b]  = stab & ~prev;
      assign fall_o[b]  = ~stab & prev;
    end
  endgenerate

endmodule : asz_pin_sync

`default_nettype wire

//--- src/asz_sensor.sv
// Serial readout, daisy chain and zero programming of the angle sensor.
//
// The implementer's own choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "asz_consts.svh"

// How it works
// - Select rising edge captures the current angle as zero candidate.
// - First long high-voltage pulse, held 200 us, enters programming mode.
// - Entering programming mode drives one acknowledge pulse on data.
// - Seven short pulses write the captured angle into one-time zero.
// - A ninth pulse permanently selects continuous readout mode.
// - Registers form one shift-chain stage fed from the programming input.
// - n chained devices need n times eight clocks plus one to empty.
// - After a select pulse, next clock falling edge starts a measurement.
// - Parallel select through a decoder keeps continuous mode usable.
// - Word goes MSB first: six angle bits, invalid flag, even parity.
// - Programmed zero is subtracted from every reported angle.
// - Continuous mode reloads the word on the ninth clock falling edge.
module asz_sensor #(
  parameter int ENTRY_CYC = `ASZ_PROGEN_CYC
) (
  input  wire logic              ref_clk_i,
  input  wire logic              sys_rst_i,
  input  wire logic [4:0]        avs_address_i,
  input  wire logic              avs_read_i,
  input  wire logic              avs_write_i,
  input  wire logic [31:0]       avs_writedata_i,
  output logic      [31:0]       avs_readdata_o,
  output logic                   avs_waitrequest_o,
  output logic                   irq_o,
  input  wire asz_pkg::asz_meas_t meas_i,
  input  wire logic              meas_valid_i,
  input  wire logic              power_down_select_n_i,
  input  wire logic              ssi_clk_i,
  input  wire logic              prog_data_i,
  input  wire logic              prog_hv_i,
  output logic                   data_o,
  output logic                   data_oe_o
);

  generate
    if (ENTRY_CYC < 1 || ENTRY_CYC > 16383)
    begin : g_chk
      $error("asz_sensor: ENTRY_CYC must be 1 to 16383");
    end
  endgenerate

  localparam logic [13:0] WAIT_CYC  = 14'(`ASZ_WAIT_CYC);
  localparam logic [13:0] ACK_LAST  = 14'(`ASZ_ACK_CYC - 1);
  localparam logic [13:0] ENTRY_MIN = 14'(ENTRY_CYC - 1);

  asz_pkg::asz_pins_t pin_raw;
  asz_pkg::asz_pins_t pin_s;
  asz_pkg::asz_pins_t pin_r;
  asz_pkg::asz_pins_t pin_f;

  assign pin_raw = '{cs_n: power_down_select_n_i, sclk: ssi_clk_i,
                     prog_data: prog_data_i, prog_hv: prog_hv_i};

  // Every host pin crosses two flops before any logic reads it
  asz_pin_sync #(
    .W       (4),
    .RST_VAL (4'hc)                                    // Select and clock idle high
  ) u_sync (
    .ref_clk_i (ref_clk_i),
    .sys_rst_i (sys_rst_i),
    .pin_i     (pin_raw),
    .level_o   (pin_s),
    .rise_o    (pin_r),
    .fall_o    (pin_f)
  );

  // Builds the output word with zero removed and even parity
  function automatic asz_pkg::asz_word_t build_word(
    input asz_pkg::asz_meas_t m,
    input logic [5:0]         zero
  );
    asz_pkg::asz_word_t w;
    w.angle   = m.angle - zero;
    w.invalid = m.invalid;
    w.parity  = ^{w.angle, w.invalid};
    return w;
  endfunction : build_word

  // Frame group state
  asz_pkg::asz_meas_t meas_q, next_meas;
  logic [7:0]         shift_q, next_shift;
  logic [7:0]         last_word_q, next_last_word;
  logic               dout_q, next_dout;
  logic               doe_q, next_doe;
  logic               frame_q, next_frame;
  logic [3:0]         fcnt_q, next_fcnt;
  logic               load;

  // Programming group state
  asz_pkg::asz_pg_t   pg_q, next_pg;
  logic [13:0]        tmr_q, next_tmr;
  logic [3:0]         pcnt_q, next_pcnt;
  logic [5:0]         cand_q, next_cand;
  logic [5:0]         zero_q, next_zero;
  logic               zero_ok_q, next_zero_ok;
  logic               cont_q, next_cont;
  logic               ev_prog, ev_zero, ev_cont;

  // Bus and interrupt group state
  logic               wait_q, next_wait;
  logic [31:0]        rdata_q, next_rdata;
  logic [3:0]         irq_st_q, next_irq_st;
  logic [3:0]         mask_q, next_mask;
  logic               ctrl_q, next_ctrl;
  logic               irq_q, next_irq;
  logic               wr_go;
  logic [3:0]         ev_all;

  // Shift register, frame counter and data pin drive
  always_comb
  begin
    next_meas      = meas_valid_i ? meas_i : meas_q;
    next_shift     = shift_q;
    next_last_word = last_word_q;
    next_dout      = dout_q;
    next_doe       = doe_q;
    next_frame     = frame_q;
    next_fcnt      = fcnt_q;
    load           = 1'b0;
    if (pin_s.cs_n)
    begin
      // Power down: pin floats except for the acknowledge pulse
      next_frame = 1'b0;
      next_fcnt  = 4'h0;
      next_doe   = (pg_q == asz_pkg::ASZ_PG_ACK);
      next_dout  = (pg_q == asz_pkg::ASZ_PG_ACK);
    end
    else
    begin
      next_doe = 1'b1;
      if (!frame_q)
        next_dout = 1'b0;
      if (pin_f.sclk)
      begin
        if (!frame_q)
        begin
          load       = 1'b1;
          next_frame = 1'b1;
          next_fcnt  = 4'h1;
        end
        else if (cont_q && fcnt_q == `ASZ_FCNT_LAST)
        begin
          load      = 1'b1;
          next_fcnt = 4'h1;
        end
        else if (fcnt_q != `ASZ_FCNT_MAX)
          next_fcnt = fcnt_q + 4'h1;
      end
      if (pin_r.sclk && frame_q)
      begin
        // Each rise moves one bit out and one chain bit in
        next_dout  = shift_q[7];
        next_shift = {shift_q[6:0], pin_s.prog_data};
      end
      if (load)
      begin
        next_shift     = build_word(meas_q, zero_q);
        next_last_word = next_shift;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      meas_q      <= '0;
      shift_q     <= 8'h00;
      last_word_q <= 8'h00;
      dout_q      <= 1'b0;
      doe_q       <= 1'b0;
      frame_q     <= 1'b0;
      fcnt_q      <= 4'h0;
    end
    else
    begin
      meas_q      <= next_meas;
      shift_q     <= next_shift;
      last_word_q <= next_last_word;
      dout_q      <= next_dout;
      doe_q       <= next_doe;
      frame_q     <= next_frame;
      fcnt_q      <= next_fcnt;
    end
  end

  // Programming sequence; one-time bits can only ever be set
  always_comb
  begin
    next_pg      = pg_q;
    next_tmr     = tmr_q;
    next_pcnt    = pcnt_q;
    next_cand    = cand_q;
    next_zero    = zero_q;
    next_zero_ok = zero_ok_q;
    next_cont    = cont_q;
    ev_prog      = 1'b0;
    ev_zero      = 1'b0;
    ev_cont      = 1'b0;
    if (pin_r.cs_n)
      next_cand = meas_q.angle;
    if (!pin_s.cs_n)
    begin
      // Dropping select abandons any sequence in progress
      next_pg   = asz_pkg::ASZ_PG_IDLE;
      next_tmr  = 14'h0000;
      next_pcnt = 4'h0;
    end
    else
    begin
      case (pg_q)
        asz_pkg::ASZ_PG_IDLE:
        begin
          if (tmr_q != 14'h3fff)
            next_tmr = tmr_q + 14'h0001;
          if (pin_r.prog_hv && tmr_q >= WAIT_CYC)
          begin
            next_pg  = asz_pkg::ASZ_PG_ENTRY;
            next_tmr = 14'h0000;
          end
        end
        asz_pkg::ASZ_PG_ENTRY:
        begin
          if (tmr_q != 14'h3fff)
            next_tmr = tmr_q + 14'h0001;
          if (pin_f.prog_hv)
          begin
            next_tmr = 14'h0000;
            if (tmr_q >= ENTRY_MIN)
            begin
              next_pg = asz_pkg::ASZ_PG_ACK;
              ev_prog = 1'b1;
            end
            else
              next_pg = asz_pkg::ASZ_PG_FAIL;
          end
        end
        asz_pkg::ASZ_PG_ACK:
        begin
          next_tmr = tmr_q + 14'h0001;
          if (tmr_q == ACK_LAST)
          begin
            next_pg   = asz_pkg::ASZ_PG_PULSES;
            next_pcnt = 4'h0;
          end
        end
        asz_pkg::ASZ_PG_PULSES:
        begin
          if (pin_r.prog_hv && pcnt_q != 4'hf)
          begin
            next_pcnt = pcnt_q + 4'h1;
            if (pcnt_q == `ASZ_ZERO_PULSES && ctrl_q && !zero_ok_q)
            begin
              next_zero    = cand_q;
              next_zero_ok = 1'b1;
              ev_zero      = 1'b1;
            end
            if (pcnt_q == `ASZ_CONT_PULSES && ctrl_q && !cont_q)
            begin
              next_cont = 1'b1;
              ev_cont   = 1'b1;
            end
          end
        end
        default:
          next_pg = asz_pkg::ASZ_PG_FAIL;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      pg_q      <= asz_pkg::ASZ_PG_IDLE;
      tmr_q     <= 14'h0000;
      pcnt_q    <= 4'h0;
      cand_q    <= 6'h00;
      zero_q    <= 6'h00;
      zero_ok_q <= 1'b0;
      cont_q    <= 1'b0;
    end
    else
    begin
      pg_q      <= next_pg;
      tmr_q     <= next_tmr;
      pcnt_q    <= next_pcnt;
      cand_q    <= next_cand;
      zero_q    <= next_zero;
      zero_ok_q <= next_zero_ok;
      cont_q    <= next_cont;
    end
  end

  // Avalon slave: answers in the cycle after the request appears
  assign wr_go  = avs_write_i && !wait_q;
  assign ev_all = {ev_cont, ev_zero, ev_prog, load};

  always_comb
  begin
    next_wait   = 1'b1;
    next_rdata  = rdata_q;
    next_mask   = mask_q;
    next_ctrl   = ctrl_q;
    next_irq_st = irq_st_q;
    if ((avs_read_i || avs_write_i) && wait_q)
    begin
      next_wait  = 1'b0;
      next_rdata = 32'h0000_0000;
      if (avs_read_i)
      begin
        if (avs_address_i == `ASZ_OFF_STATUS)
          next_rdata = {20'h0_0000, cont_q, zero_ok_q,
                        pg_q == asz_pkg::ASZ_PG_PULSES, frame_q,
                        last_word_q};
        else if (avs_address_i == `ASZ_OFF_ZERO)
          next_rdata = {18'h0_0000, cand_q, 2'h0, zero_q};
        else if (avs_address_i == `ASZ_OFF_IRQ_ST)
          next_rdata = {28'h000_0000, irq_st_q};
        else if (avs_address_i == `ASZ_OFF_IRQ_MASK)
          next_rdata = {28'h000_0000, mask_q};
        else if (avs_address_i == `ASZ_OFF_CTRL)
          next_rdata = {31'h0000_0000, ctrl_q};
      end
    end
    // Write-one clears, but a new event in the same cycle stays set
    if (wr_go && avs_address_i == `ASZ_OFF_IRQ_ST)
      next_irq_st = irq_st_q & ~avs_writedata_i[3:0];
    next_irq_st = next_irq_st | ev_all;
    if (wr_go && avs_address_i == `ASZ_OFF_IRQ_MASK)
      next_mask = avs_writedata_i[3:0];
    if (wr_go && avs_address_i == `ASZ_OFF_CTRL)
      next_ctrl = avs_writedata_i[`ASZ_CTRL_PROG_EN];
    next_irq = |(irq_st_q & mask_q);
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      wait_q   <= 1'b1;
      rdata_q  <= 32'h0000_0000;
      irq_st_q <= 4'h0;
      mask_q   <= `ASZ_MASK_RST;
      ctrl_q   <= `ASZ_CTRL_RST;
      irq_q    <= 1'b0;
    end
    else
    begin
      wait_q   <= next_wait;
      rdata_q  <= next_rdata;
      irq_st_q <= next_irq_st;
      mask_q   <= next_mask;
      ctrl_q   <= next_ctrl;
      irq_q    <= next_irq;
    end
  end

  assign avs_readdata_o    = rdata_q;
  assign avs_waitrequest_o = wait_q;
  assign irq_o             = irq_q;
  assign data_o            = dout_q;
  assign data_oe_o         = doe_q;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  parity_even_a: assert property (
    load |=> (^shift_q == 1'b0))
    else $error("loaded word has odd parity");

  zero_wrap_a: assert property (
    load |=> shift_q[7:2] == 6'($past(meas_q.angle) - $past(zero_q)))
    else $error("reported angle not measured minus zero");

  msb_first_a: assert property (
    (pin_r.sclk && frame_q && !pin_s.cs_n) |=> dout_q == $past(shift_q[7]))
    else $error("data pin did not show shift msb");

  chain_stage_a: assert property (
    (pin_r.sclk && frame_q && !pin_s.cs_n)
      |=> shift_q[0] == $past(pin_s.prog_data))
    else $error("chain input not shifted in");

  float_deselect_a: assert property (
    (pin_s.cs_n && pg_q != asz_pkg::ASZ_PG_ACK) |=> !doe_q)
    else $error("data driven while deselected");

  capture_rise_a: assert property (
    pin_r.cs_n |=> cand_q == $past(meas_q.angle))
    else $error("zero candidate not captured");

  ack_pulse_a: assert property (
    $rose(pg_q == asz_pkg::ASZ_PG_ACK) && pin_s.cs_n
      |=> (doe_q && dout_q) [*2])
    else $error("acknowledge pulse missing");

  entry_time_a: assert property (
    $rose(pg_q == asz_pkg::ASZ_PG_ACK) |-> $past(tmr_q) >= ENTRY_MIN)
    else $error("programming entered on short pulse");

  cont_reload_a: assert property (
    (pin_f.sclk && !pin_s.cs_n && frame_q && cont_q
      && fcnt_q == `ASZ_FCNT_LAST)
      |=> fcnt_q == 4'h1 && last_word_q == $past(build_word(meas_q, zero_q)))
    else $error("continuous reload missed");

  otp_keep_a: assert property (
    zero_ok_q |=> zero_ok_q && $stable(zero_q))
    else $error("programmed zero changed");

  cont_keep_a: assert property (
    cont_q |=> cont_q)
    else $error("continuous mode lost");

  new_frame_a: assert property (
    (pin_f.sclk && !pin_s.cs_n && !frame_q) |=> frame_q && fcnt_q == 4'h1)
    else $error("measurement not started on falling edge");

endmodule : asz_sensor

`default_nettype wire

//--- sim/asz_host_model.sv
// Host model: drives select, serial clock and the programming pin.
`timescale 1ns/1ps
`default_nettype none

module asz_host_model (
  input  wire logic ref_clk_i,
  input  wire logic data_i,
  input  wire logic data_oe_i,
  output var  logic select_n_o,
  output var  logic ssi_clk_o,
  output var  logic prog_data_o,
  output var  logic prog_hv_o
);
  logic        last_q = 1'b0;
  logic        pin;
  logic [15:0] bits;

  // A released pin has no pull, so it shows the inverse of its last level
  always @(posedge ref_clk_i)
  begin
    if (data_oe_i)
      last_q <= data_i;
  end
  assign pin = data_oe_i ? data_i : ~last_q;

  initial
  begin
    select_n_o  = 1'b1;
    ssi_clk_o   = 1'b1;
    prog_data_o = 1'b0;
    prog_hv_o   = 1'b0;
  end

  // Every call starts and ends right after a rising ref_clk edge
  task automatic wait_clk(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask : wait_clk

  // Power-up set-up plus latch time before any clocking
  task automatic power_up;
    wait_clk(200 * 50 + 5 * 50);
  endtask : power_up

  // Each sensor has its own select line, as behind a decoder
  task automatic select(input logic lvl, input int settle);
    select_n_o <= lvl;
    wait_clk(settle);
  endtask : select

  // Clock stands high between frames; 160 ns period, bits read while low
  task automatic clock_bits(input int n, input logic [7:0] pat);
    bits = '0;
    for (int i = 0; i <= n; i++)
    begin
      ssi_clk_o   <= 1'b0;
      prog_data_o <= (i < 8) ? pat[7 - i] : 1'b0;
      wait_clk(2);
      if (i > 0)
        bits = {bits[14:0], pin};
      wait_clk(2);
      ssi_clk_o <= 1'b1;
      wait_clk(4);
    end
  endtask : clock_bits

  // Select stays high from capture to the last zap pulse
  task automatic program_zero(input int entry, input int zaps);
    select_n_o <= 1'b1;
    wait_clk(30);
    prog_hv_o <= 1'b1;
    wait_clk(entry);
    prog_hv_o <= 1'b0;
    wait_clk(300);
    for (int i = 0; i < zaps; i++)
    begin
      prog_hv_o <= 1'b1;
      wait_clk(250);
      prog_hv_o <= 1'b0;
      wait_clk(250);
    end
  endtask : program_zero
endmodule : asz_host_model

`default_nettype wire

//--- sim/testbench.sv
// Self-checking bench for the angle sensor readout and programming.
`timescale 1ns/1ps
`default_nettype none
`include "asz_consts.svh"

module testbench;
  // Short entry pulse keeps the run brief
  localparam int ENTRY = 20;

  logic               ref_clk_i;
  logic               sys_rst_i;
  logic [4:0]         avs_address;
  logic               avs_read;
  logic               avs_write;
  logic [31:0]        avs_writedata;
  logic [31:0]        avs_readdata;
  logic               avs_waitrequest;
  logic               irq;
  asz_pkg::asz_meas_t meas;
  logic               meas_valid;
  logic               sel_n;
  logic               sclk;
  logic               pdata;
  logic               phv;
  logic               data;
  logic               data_oe;
  logic [31:0]        rd;
  int                 errors;
  int                 samples_checked;

  asz_sensor #(.ENTRY_CYC(ENTRY)) DUT (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .avs_address_i(avs_address), .avs_read_i(avs_read),
    .avs_write_i(avs_write), .avs_writedata_i(avs_writedata),
    .avs_readdata_o(avs_readdata), .avs_waitrequest_o(avs_waitrequest),
    .irq_o(irq), .meas_i(meas), .meas_valid_i(meas_valid),
    .power_down_select_n_i(sel_n), .ssi_clk_i(sclk),
    .prog_data_i(pdata), .prog_hv_i(phv),
    .data_o(data), .data_oe_o(data_oe));

  asz_host_model host (
    .ref_clk_i(ref_clk_i), .data_i(data), .data_oe_i(data_oe),
    .select_n_o(sel_n), .ssi_clk_o(sclk),
    .prog_data_o(pdata), .prog_hv_o(phv));

  initial
  begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end

  task automatic complete_run;
    if (errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string msg);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t ns: %s", $time, msg);
    end
  endtask : chk

  // Expected word: offset angle wraps in six bits, parity makes it even
  function automatic logic [7:0] word_of(input logic [5:0] a,
                                         input logic inv,
                                         input logic [5:0] zero);
    logic [5:0] d;
    d = a - zero;
    return {d, inv, ^{d, inv}};
  endfunction : word_of

  // One Avalon access; request held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [4:0] addr,
                     input logic [31:0] wdata);
    int n;
    avs_address   <= addr;
    avs_writedata <= wdata;
    avs_write     <= wr;
    avs_read      <= ~wr;
    n = 0;
    do
    begin
      @(posedge ref_clk_i);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk_i);
    if (n >= 50)
    begin
      errors++;
      complete_run();
    end
  endtask : bus

  task automatic new_meas(input logic [5:0] a, input logic inv);
    meas       <= '{angle: a, invalid: inv};
    meas_valid <= 1'b1;
    @(posedge ref_clk_i);
    meas_valid <= 1'b0;
    @(posedge ref_clk_i);
  endtask : new_meas

  // Reset values, unmapped place, single word and its interrupt
  task automatic t_single;
    bus(1'b0, `ASZ_OFF_CTRL, 32'h0000_0000);
    chk(rd, 32'h0000_0001, "ctrl reset");
    bus(1'b0, `ASZ_OFF_IRQ_MASK, 32'h0000_0000);
    chk(rd, 32'h0000_0000, "mask reset");
    bus(1'b1, 5'h14, 32'hffff_ffff);
    bus(1'b0, 5'h14, 32'h0000_0000);
    chk(rd, 32'h0000_0000, "unmapped");
    chk(32'(data_oe), 32'h0000_0000, "float when deselected");
    new_meas(6'h2d, 1'b0);
    host.select(1'b0, 20);
    chk(32'({data_oe, data}), 32'h0000_0002, "driven low");
    host.clock_bits(8, 8'h00);
    chk(32'(host.bits[7:0]), 32'(word_of(6'h2d, 1'b0, 6'h00)), "word");
    bus(1'b0, `ASZ_OFF_STATUS, 32'h0000_0000);
    chk(32'(rd[7:0]), 32'(word_of(6'h2d, 1'b0, 6'h00)), "status word");
    chk(32'(irq), 32'h0000_0000, "irq masked");
    bus(1'b1, `ASZ_OFF_IRQ_MASK, 32'h0000_0001);
    host.wait_clk(3);
    chk(32'(irq), 32'h0000_0001, "irq raised");
    bus(1'b1, `ASZ_OFF_IRQ_ST, 32'h0000_0001);
    host.wait_clk(3);
    chk(32'(irq), 32'h0000_0000, "irq cleared");
    host.select(1'b1, 60);
    chk(32'(data_oe), 32'h0000_0000, "float after select");
  endtask : t_single

  // Two-device chain emulated: own word, then the chain input
  task automatic t_chain;
    new_meas(6'h0a, 1'b1);
    host.select(1'b0, 20);
    host.clock_bits(16, 8'hb4);
    chk(32'(host.bits[15:8]), 32'(word_of(6'h0a, 1'b1, 6'h00)), "own");
    chk(32'(host.bits[7:0]), 32'h0000_00b4, "shifted through");
    host.select(1'b1, 60);
    new_meas(6'h31, 1'b0);
    host.select(1'b0, 20);
    host.clock_bits(8, 8'h00);
    chk(32'(host.bits[7:0]), 32'(word_of(6'h31, 1'b0, 6'h00)), "fresh");
  endtask : t_chain

  // Zero and continuous programming, then offset and reload
  task automatic t_prog;
    int n;
    // A too short entry pulse must leave the part dead until select drops
    host.program_zero(ENTRY - 10, 0);
    bus(1'b0, `ASZ_OFF_IRQ_ST, 32'h0000_0000);
    chk(32'(rd[1]), 32'h0000_0000, "short entry refused");
    chk(32'(data_oe), 32'h0000_0000, "no ack on short entry");
    host.select(1'b0, 20);
    new_meas(6'h13, 1'b0);
    fork
      host.program_zero(ENTRY + 5, 8);
      begin
        n = 0;
        while (!(data_oe === 1'b1 && data === 1'b1) && n < 200)
        begin
          @(posedge ref_clk_i);
          n++;
        end
        chk(32'(n < 200), 32'h0000_0001, "ack seen");
        if (n >= 200)
          complete_run();
        host.wait_clk(240);
        chk(32'({data_oe, data}), 32'h0000_0003, "ack held");
      end
    join
    bus(1'b0, `ASZ_OFF_ZERO, 32'h0000_0000);
    chk(32'(rd[5:0]), 32'h0000_0013, "zero");
    bus(1'b0, `ASZ_OFF_IRQ_ST, 32'h0000_0000);
    chk(32'(rd[3:1]), 32'h0000_0007, "prog events");
    bus(1'b0, `ASZ_OFF_STATUS, 32'h0000_0000);
    chk(32'(rd[11:10]), 32'h0000_0003, "modes set");
    new_meas(6'h05, 1'b0);
    host.select(1'b0, 20);
    fork
      host.clock_bits(16, 8'h00);
      begin
        host.wait_clk(40);
        new_meas(6'h3a, 1'b1);
      end
    join
    chk(32'(host.bits[15:8]), 32'(word_of(6'h05, 1'b0, 6'h13)), "wrap");
    chk(32'(host.bits[7:0]), 32'(word_of(6'h3a, 1'b1, 6'h13)), "reload");
  endtask : t_prog

  initial
  begin
    errors          = 0;
    samples_checked = 0;
    sys_rst_i       = 1'b1;
    avs_address     = 5'h00;
    avs_read        = 1'b0;
    avs_write       = 1'b0;
    avs_writedata   = 32'h0000_0000;
    meas            = '0;
    meas_valid      = 1'b0;
    repeat (6) @(posedge ref_clk_i);
    chk(32'({irq, data_oe}), 32'h0000_0000, "reset outputs");
    sys_rst_i <= 1'b0;
    @(posedge ref_clk_i);
    host.power_up();
    t_single();
    t_chain();
    t_prog();
    complete_run();
  end

  // Guard against a hang anywhere in the sequence
  initial
  begin
    #1_000_000;
    errors++;
    complete_run();
  end
endmodule : testbench

`default_nettype wire
